//--- hw/pdc_divider_config.sv
// PLL reference and feedback divider registers and counter control
`include "pdc_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module pdc_divider_config (
   input  wire logic        clk_sys,         // 250 MHz system clock
   input  wire logic        reset,           // Async reset, active high
   input  wire logic [9:0]  avs_address,     // Byte address
   input  wire logic        avs_read,        // Read request
   input  wire logic        avs_write,       // Write request
   input  wire logic [31:0] avs_writedata,   // Write data, low byte used
   input  wire logic [3:0]  avs_byteenable,  // Byte lanes
   output logic      [31:0] avs_readdata,    // Read data
   output logic             avs_waitrequest, // Low for the answer cycle
   input  wire logic        ref_tick,        // Reference edge event
   input  wire logic        presc_tick,      // Prescaler output event
   input  wire logic        fixed_divide_mode, // Prescaler mode pin
   output logic             ref_div_pulse,   // Reference divider output
   output logic             fb_div_pulse,    // Feedback divider output
   output logic             modulus_sel,     // Prescaler uses P+1
   output logic             charge_pump_midsupply, // Pump at half supply
   output logic             ref_hold,        // Reference counter held
   output logic             fb_hold          // Feedback counters held
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   pdc_pkg::pdc_bus_e  bus_state_q;
   pdc_pkg::pdc_ctrl_s ctrl_q;
   logic [13:0]        ref_div_q;
   logic [5:0]         swallow_q;
   logic [12:0]        main_q;
   logic [7:0]         index_w;
   logic               req_w;
   logic               wr_commit_w;
   logic [7:0]         rd_byte_w;
   logic               rd_hit_w;
   logic               mode_meta_q;
   logic               mode_sync_q;
   logic               bypass_eff_w;
   logic [12:0]        main_div_w;
   logic [5:0]         swallow_cnt_q;
   logic               ref_hold_d;
   logic               fb_hold_d;

   assign index_w = avs_address[9:2];
   assign req_w   = avs_read | avs_write;

   // ---------------------------------------------------------------
   // Bus answer sequencer
   // ---------------------------------------------------------------
   // Every access answers on the second edge: one edge to fetch read
   // data into a flop, so read data never comes from a long mux path
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         bus_state_q     <= pdc_pkg::PDC_BUS_IDLE;
         avs_waitrequest <= 1'b1;
      end else begin
         case (bus_state_q)
            pdc_pkg::PDC_BUS_IDLE: begin
               if (req_w) begin
                  bus_state_q     <= pdc_pkg::PDC_BUS_ANSWER;
                  avs_waitrequest <= 1'b0;
               end
            end
            pdc_pkg::PDC_BUS_ANSWER: begin
               bus_state_q     <= pdc_pkg::PDC_BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
            default: begin
               bus_state_q     <= pdc_pkg::PDC_BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // Write lands on the edge where the master sees waitrequest low
   assign wr_commit_w = avs_write && !avs_waitrequest &&
                        avs_byteenable[0];

   // ---------------------------------------------------------------
   // Read multiplexer
   // ---------------------------------------------------------------
   // Unused upper bits and unmapped addresses read as zero
   always_comb begin
      rd_byte_w = 8'h00;
      rd_hit_w  = 1'b1;
      case (index_w)
         `PDC_IDX_REF_LOW:   rd_byte_w = ref_div_q[7:0];
         `PDC_IDX_REF_HIGH:  rd_byte_w = {2'h0, ref_div_q[13:8]};
         `PDC_IDX_SWALLOW:   rd_byte_w = {2'h0, swallow_q};
         `PDC_IDX_MAIN_LOW:  rd_byte_w = main_q[7:0];
         `PDC_IDX_MAIN_HIGH: rd_byte_w = {3'h0, main_q[12:8]};
         `PDC_IDX_CTRL:      rd_byte_w = {ctrl_q, 3'h0};
         default:            rd_hit_w  = 1'b0;
      endcase
      if (!rd_hit_w) begin
         rd_byte_w = 8'h00;
      end
   end

   // Read data captured when the request is first seen
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         avs_readdata <= 32'h0000_0000;
      end else if (bus_state_q == pdc_pkg::PDC_BUS_IDLE && avs_read) begin
         avs_readdata <= {24'h00_0000, rd_byte_w};
      end
   end

   // ---------------------------------------------------------------
   // Divider value registers
   // ---------------------------------------------------------------
   // Reference divider, split over two byte registers
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ref_div_q <= {`PDC_RST_REF_HIGH, `PDC_RST_REF_LOW};
      end else if (wr_commit_w && index_w == `PDC_IDX_REF_LOW) begin
         ref_div_q[7:0] <= avs_writedata[7:0];
      end else if (wr_commit_w && index_w == `PDC_IDX_REF_HIGH) begin
         ref_div_q[13:8] <= avs_writedata[5:0];
      end
   end

   // Swallow count, part of the feedback divider
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         swallow_q <= `PDC_RST_SWALLOW;
      end else if (wr_commit_w && index_w == `PDC_IDX_SWALLOW) begin
         swallow_q <= avs_writedata[5:0];
      end
   end

   // Main counter, split over two byte registers
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         main_q <= {`PDC_RST_MAIN_HIGH, `PDC_RST_MAIN_LOW};
      end else if (wr_commit_w && index_w == `PDC_IDX_MAIN_LOW) begin
         main_q[7:0] <= avs_writedata[7:0];
      end else if (wr_commit_w && index_w == `PDC_IDX_MAIN_HIGH) begin
         main_q[12:8] <= avs_writedata[4:0];
      end
   end

   // Counter-control register; bits 2..0 are reserved
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ctrl_q <= `PDC_RST_CTRL;
      end else if (wr_commit_w && index_w == `PDC_IDX_CTRL) begin
         ctrl_q.pump_mid <= avs_writedata[`PDC_BIT_PUMP_MID];
         ctrl_q.rst_ref  <= avs_writedata[`PDC_BIT_RST_REF];
         ctrl_q.rst_fb   <= avs_writedata[`PDC_BIT_RST_FB];
         ctrl_q.rst_all  <= avs_writedata[`PDC_BIT_RST_ALL];
         ctrl_q.main_byp <= avs_writedata[`PDC_BIT_MAIN_BYP];
      end
   end

   // ---------------------------------------------------------------
   // Mode pin synchroniser
   // ---------------------------------------------------------------
   // Pin is asynchronous to clk_sys; only the second flop is used
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mode_meta_q <= 1'b0;
         mode_sync_q <= 1'b0;
      end else begin
         mode_meta_q <= fixed_divide_mode;
         mode_sync_q <= mode_meta_q;
      end
   end

   // ---------------------------------------------------------------
   // Counter holds and pump control
   // ---------------------------------------------------------------
   // Own bit and global bit are ORed for each counter
   assign ref_hold_d = ctrl_q.rst_ref | ctrl_q.rst_all;
   assign fb_hold_d  = ctrl_q.rst_fb  | ctrl_q.rst_all;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ref_hold              <= 1'b0;
         fb_hold               <= 1'b0;
         charge_pump_midsupply <= 1'b0;
      end else begin
         ref_hold              <= ref_hold_d;
         fb_hold               <= fb_hold_d;
         charge_pump_midsupply <= ctrl_q.pump_mid;
      end
   end

   // ---------------------------------------------------------------
   // Reference divider
   // ---------------------------------------------------------------
   pdc_div_counter #(
      .WIDTH (14)
   ) u_ref_cnt (
      .clk_sys (clk_sys),
      .reset   (reset),
      .tick    (ref_tick),
      .hold    (ref_hold),
      .divisor (ref_div_q),
      .pulse   (ref_div_pulse)
   );

   // ---------------------------------------------------------------
   // Feedback divider: main counter
   // ---------------------------------------------------------------
   // Bypass is ignored outside fixed-divide mode, where the swallow
   // sequence needs a real main count to work against
   assign bypass_eff_w = ctrl_q.main_byp & mode_sync_q;
   assign main_div_w   = bypass_eff_w ? 13'h0001 : main_q;

   pdc_div_counter #(
      .WIDTH (13)
   ) u_main_cnt (
      .clk_sys (clk_sys),
      .reset   (reset),
      .tick    (presc_tick),
      .hold    (fb_hold),
      .divisor (main_div_w),
      .pulse   (fb_div_pulse)
   );

   // ---------------------------------------------------------------
   // Feedback divider: swallow counter
   // ---------------------------------------------------------------
   // Reloads at each feedback cycle; while nonzero the prescaler runs
   // at the higher modulus. Fixed-divide mode never swallows.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         swallow_cnt_q <= 6'h00;
      end else if (fb_hold) begin
         swallow_cnt_q <= swallow_q;
      end else if (fb_div_pulse) begin
         swallow_cnt_q <= swallow_q;
      end else if (presc_tick && swallow_cnt_q != 6'h00) begin
         swallow_cnt_q <= swallow_cnt_q - 6'h01;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         modulus_sel <= 1'b0;
      end else begin
         modulus_sel <= !mode_sync_q && !fb_hold &&
                        swallow_cnt_q != 6'h00;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_answer_next: assert property (@(posedge clk_sys) disable iff (reset)
      (req_w && bus_state_q == pdc_pkg::PDC_BUS_IDLE)
      |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle after request");

   a_read_ref_low: assert property (@(posedge clk_sys)
      disable iff (reset)
      (avs_read && !avs_waitrequest &&
       index_w == `PDC_IDX_REF_LOW)
      |-> avs_readdata == {24'h00_0000, ref_div_q[7:0]})
      else $error("reference low byte reads back wrong");

   a_write_ref_hi: assert property (@(posedge clk_sys)
      disable iff (reset)
      (wr_commit_w && index_w == `PDC_IDX_REF_HIGH)
      |=> ref_div_q[13:8] == $past(avs_writedata[5:0]))
      else $error("reference high bits not written");

   a_write_swallow: assert property (@(posedge clk_sys)
      disable iff (reset)
      (wr_commit_w && index_w == `PDC_IDX_SWALLOW)
      |=> swallow_q == $past(avs_writedata[5:0]))
      else $error("swallow count not written");

   a_write_main_lo: assert property (@(posedge clk_sys)
      disable iff (reset)
      (wr_commit_w && index_w == `PDC_IDX_MAIN_LOW)
      |=> main_q[7:0] == $past(avs_writedata[7:0]))
      else $error("main low byte not written");

   a_write_main_hi: assert property (@(posedge clk_sys)
      disable iff (reset)
      (wr_commit_w && index_w == `PDC_IDX_MAIN_HIGH)
      |=> main_q[12:8] == $past(avs_writedata[4:0]))
      else $error("main high bits not written");

   a_pump_park: assert property (@(posedge clk_sys) disable iff (reset)
      (wr_commit_w && index_w == `PDC_IDX_CTRL)
      |=> ##1 charge_pump_midsupply == $past(avs_writedata[7], 2))
      else $error("pump park does not follow control bit");

   a_ref_hold_or: assert property (@(posedge clk_sys) disable iff (reset)
      (ctrl_q.rst_ref || ctrl_q.rst_all) |=> ref_hold)
      else $error("reference counter not held");

   a_fb_hold_or: assert property (@(posedge clk_sys) disable iff (reset)
      (ctrl_q.rst_fb || ctrl_q.rst_all) |=> fb_hold ##1 !fb_div_pulse)
      else $error("feedback counters not held");

   a_all_release: assert property (@(posedge clk_sys) disable iff (reset)
      (!ctrl_q.rst_ref && !ctrl_q.rst_all) |=> !ref_hold)
      else $error("reference hold stuck without cause");

   a_bypass_gate: assert property (@(posedge clk_sys) disable iff (reset)
      !mode_sync_q |-> main_div_w == main_q)
      else $error("bypass acted outside fixed-divide mode");

   a_bypass_div1: assert property (@(posedge clk_sys) disable iff (reset)
      (bypass_eff_w && presc_tick && !fb_hold) |=> fb_div_pulse)
      else $error("bypassed main counter did not divide by one");

   a_mode_no_swallow: assert property (@(posedge clk_sys) disable iff (reset)
      mode_sync_q |=> !modulus_sel)
      else $error("swallow active in fixed-divide mode");

endmodule : pdc_divider_config

`default_nettype wire

//--- include/pdc_defs.svh
// Register indices, field positions, reset values of the PLL divider block
`ifndef PDC_DEFS_SVH
`define PDC_DEFS_SVH

// ------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------------
`define PDC_IDX_REF_LOW    8'h11
`define PDC_IDX_REF_HIGH   8'h12
`define PDC_IDX_SWALLOW    8'h13
`define PDC_IDX_MAIN_LOW   8'h14
`define PDC_IDX_MAIN_HIGH  8'h15
`define PDC_IDX_CTRL       8'h16

// ------------------------------------------------------------------
// Field positions of the counter-control register
// ------------------------------------------------------------------
`define PDC_BIT_PUMP_MID   7
`define PDC_BIT_RST_REF    6
`define PDC_BIT_RST_FB     5
`define PDC_BIT_RST_ALL    4
`define PDC_BIT_MAIN_BYP   3

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define PDC_RST_REF_LOW    8'h01
`define PDC_RST_REF_HIGH   6'h00
`define PDC_RST_SWALLOW    6'h00
`define PDC_RST_MAIN_LOW   8'h03
`define PDC_RST_MAIN_HIGH  5'h00
`define PDC_RST_CTRL       5'h00

`endif

//--- include/pdc_pkg.sv
// Types shared by the PLL divider configuration block
package pdc_pkg;

   // ---------------------------------------------------------------
   // Counter-control register contents
   // ---------------------------------------------------------------
   typedef struct packed {
      logic pump_mid;   // Park pump output at half supply
      logic rst_ref;    // Hold reference counter
      logic rst_fb;     // Hold swallow and main counters
      logic rst_all;    // Hold every counter
      logic main_byp;   // Main counter divides by one, in fixed-divide mode only
   } pdc_ctrl_s;

   // ---------------------------------------------------------------
   // Bus answer sequencer
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      PDC_BUS_IDLE   = 2'b00,
      PDC_BUS_ANSWER = 2'b01
   } pdc_bus_e;

endpackage : pdc_pkg

//--- hw/pdc_div_counter.sv
// Programmable divide-by-N counter with hold, one pulse per N ticks
`timescale 1ns/10ps
`default_nettype none

module pdc_div_counter #(
   parameter int WIDTH = 14
) (
   input  wire logic             clk_sys,  // System clock
   input  wire logic             reset,    // Async reset, active high
   input  wire logic             tick,     // Input clock event
   input  wire logic             hold,     // Hold counter in reset
   input  wire logic [WIDTH-1:0] divisor,  // Divide ratio, 0 acts as 1
   output logic                  pulse     // One pulse per N ticks
);

   logic [WIDTH-1:0] cnt_q;
   logic             last_w;

   // ---------------------------------------------------------------
   // Terminal count
   // ---------------------------------------------------------------
   // Divisor 0 and 1 both give divide-by-one, no dead setting
   assign last_w = (divisor <= WIDTH'(1)) ||
                   (cnt_q >= divisor - WIDTH'(1));

   // Count ticks; hold parks the counter at its start
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cnt_q <= '0;
         pulse <= 1'b0;
      end else if (hold) begin
         cnt_q <= '0;
         pulse <= 1'b0;
      end else if (tick) begin
         if (last_w) begin
            cnt_q <= '0;
            pulse <= 1'b1;
         end else begin
            cnt_q <= cnt_q + WIDTH'(1);
            pulse <= 1'b0;
         end
      end else begin
         pulse <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_hold_silent: assert property (@(posedge clk_sys) disable iff (reset)
      hold |=> (!pulse && cnt_q == '0))
      else $error("divider pulsed or counted while held");

   a_pulse_cause: assert property (@(posedge clk_sys) disable iff (reset)
      pulse |-> $past(tick) && !$past(hold))
      else $error("divider pulse without a tick");

endmodule : pdc_div_counter

`default_nettype wire

//--- verification/pdc_divider_config_test.sv
// Self-checking bench for the PLL divider configuration block
`include "pdc_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module pdc_divider_config_test;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic        clk_sys;
   logic        reset;
   logic [9:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        ref_tick;
   logic        presc_tick;
   logic        fixed_divide_mode;
   logic        ref_div_pulse;
   logic        fb_div_pulse;
   logic        modulus_sel;
   logic        charge_pump_midsupply;
   logic        ref_hold;
   logic        fb_hold;
   int          mismatches;
   int          tests_run;
   int          ref_cnt;
   int          fb_cnt;

   pdc_divider_config pdc_divider_config_inst (
      .clk_sys               (clk_sys),
      .reset                 (reset),
      .avs_address           (avs_address),
      .avs_read              (avs_read),
      .avs_write             (avs_write),
      .avs_writedata         (avs_writedata),
      .avs_byteenable        (avs_byteenable),
      .avs_readdata          (avs_readdata),
      .avs_waitrequest       (avs_waitrequest),
      .ref_tick              (ref_tick),
      .presc_tick            (presc_tick),
      .fixed_divide_mode     (fixed_divide_mode),
      .ref_div_pulse         (ref_div_pulse),
      .fb_div_pulse          (fb_div_pulse),
      .modulus_sel           (modulus_sel),
      .charge_pump_midsupply (charge_pump_midsupply),
      .ref_hold              (ref_hold),
      .fb_hold               (fb_hold)
   );

   // 250 MHz clock
   initial clk_sys = 1'b0;
   always #2 clk_sys = ~clk_sys;

   // Pulse counters; pulses are registered, so the edge sees settled values
   always @(posedge clk_sys) begin
      if (ref_div_pulse === 1'b1) ref_cnt++;
      if (fb_div_pulse === 1'b1) fb_cnt++;
   end

   // ---------------------------------------------------------------
   // Checking helpers
   // ---------------------------------------------------------------
   task automatic end_sim;
      if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim

   task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp,
                          input string msg);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : cmp_val

   task automatic cmp_flag(input logic got, input logic exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %b exp %b", $time, msg, got, exp);
      end
   endtask : cmp_flag

   task automatic cmp_count(input int got, input int exp, input string msg);
      tests_run++;
      if (got != exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %0d exp %0d", $time, msg, got, exp);
      end
   endtask : cmp_count

   // Divisor 0 behaves as 1, so every tick gives a pulse
   function automatic int exp_pulses(input int ticks, input int div);
      return (div <= 1) ? ticks : ticks / div;
   endfunction : exp_pulses

   // ---------------------------------------------------------------
   // Avalon-MM master: hold request until waitrequest is sampled low
   // ---------------------------------------------------------------
   task automatic bus_xfer(input logic [7:0] idx, input logic wr,
                           input logic [7:0] wd, input logic [3:0] be,
                           output logic [7:0] rd);
      int n;
      @(posedge clk_sys);
      avs_address    <= {idx, 2'b00};
      avs_write      <= wr;
      avs_read       <= ~wr;
      avs_writedata  <= {24'h000000, wd};
      avs_byteenable <= be;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata[7:0];
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      cmp_count(n, 2, "bus wait cycles");
   endtask : bus_xfer

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] unused;
      bus_xfer(idx, 1'b1, d, 4'hf, unused);
   endtask : wr

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] got;
      bus_xfer(idx, 1'b0, 8'h00, 4'hf, got);
      cmp_val(got, exp, "register read");
   endtask : rd_chk

   // Watchdog; the whole run needs well under this many cycles
   initial begin
      repeat (40000) @(posedge clk_sys);
      mismatches++;
      end_sim();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [7:0] idx_tab [6];
      logic [7:0] rst_tab [6];
      logic [7:0] msk_tab [6];
      logic [7:0] v;
      logic [7:0] c;
      logic       fdm;
      logic       msel;
      int         r, b, nr, nf, r0, f0, t1, t2, er, ef;
      idx_tab = '{`PDC_IDX_REF_LOW, `PDC_IDX_REF_HIGH, `PDC_IDX_SWALLOW,
                  `PDC_IDX_MAIN_LOW, `PDC_IDX_MAIN_HIGH, `PDC_IDX_CTRL};
      rst_tab = '{8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
      msk_tab = '{8'hff, 8'h3f, 8'h3f, 8'hff, 8'h1f, 8'hf8};
      reset = 1'b1;
      avs_address = 10'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hf;
      ref_tick = 1'b0;
      presc_tick = 1'b0;
      fixed_divide_mode = 1'b0;
      void'($urandom(32'hfa3c766d));
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      // Reset values of every register
      for (int i = 0; i < 6; i++) begin
         rd_chk(idx_tab[i], rst_tab[i]);
      end
      // Random write and read-back, reserved bits read zero
      for (int k = 0; k < 3; k++) begin
         for (int i = 0; i < 5; i++) begin
            v = $urandom;
            wr(idx_tab[i], v);
            rd_chk(idx_tab[i], v & msk_tab[i]);
         end
      end
      // Lane 0 disabled leaves the byte alone; unmapped places read zero
      v = 8'($urandom);
      wr(`PDC_IDX_REF_LOW, v);
      bus_xfer(`PDC_IDX_REF_LOW, 1'b1, ~v, 4'he, c);
      rd_chk(`PDC_IDX_REF_LOW, v);
      wr(8'h10, 8'hff);
      rd_chk(8'h10, 8'h00);
      rd_chk(8'h17, 8'h00);
      // Holds, pump parking, bypass and divide ratios
      for (int it = 0; it < 16; it++) begin
         r = $urandom_range(6, 0);
         b = $urandom_range(6, 0);
         c = 8'($urandom);
         fdm = 1'($urandom);
         if (it < 3) c = (it == 0) ? 8'h00 : 8'h08;
         if (it < 3) fdm = (it != 1);
         fixed_divide_mode <= fdm;
         wr(`PDC_IDX_CTRL, 8'h10);
         wr(`PDC_IDX_REF_LOW, r[7:0]);
         wr(`PDC_IDX_REF_HIGH, 8'h00);
         wr(`PDC_IDX_MAIN_LOW, b[7:0]);
         wr(`PDC_IDX_MAIN_HIGH, 8'h00);
         v = 8'($urandom);
         wr(`PDC_IDX_SWALLOW, v);
         wr(`PDC_IDX_CTRL, c);
         repeat (3) @(posedge clk_sys);
         cmp_flag(ref_hold, c[6] | c[4], "ref hold");
         cmp_flag(fb_hold, c[5] | c[4], "fb hold");
         cmp_flag(charge_pump_midsupply, c[7], "pump park");
         // Swallow count reloaded while held, so it is still full here
         msel = !fdm && !(c[5] | c[4]) && (v[5:0] != 6'h00);
         cmp_flag(modulus_sel, msel, "modulus select");
         rd_chk(`PDC_IDX_CTRL, c & msk_tab[5]);
         nr = 0;
         nf = 0;
         r0 = ref_cnt;
         f0 = fb_cnt;
         repeat (48) begin
            @(posedge clk_sys);
            t1 = $urandom % 2;
            t2 = $urandom % 2;
            ref_tick <= t1[0];
            presc_tick <= t2[0];
            nr += t1;
            nf += t2;
         end
         @(posedge clk_sys);
         ref_tick <= 1'b0;
         presc_tick <= 1'b0;
         repeat (4) @(posedge clk_sys);
         er = (c[6] | c[4]) ? 0 : exp_pulses(nr, r);
         ef = (c[3] && fdm) ? 1 : b;
         ef = (c[5] | c[4]) ? 0 : exp_pulses(nf, ef);
         cmp_count(ref_cnt - r0, er, "ref pulses");
         cmp_count(fb_cnt - f0, ef, "fb pulses");
      end
      end_sim();
   end
endmodule : pdc_divider_config_test

`default_nettype wire
